// File: rtl/otic_top.sv
// Input-capture timer and protected oscillator trim registers
`timescale 1ns/1ps
`default_nettype none
module otic_top
(
  input wire logic clock,
  input wire logic rst,
  input wire otic_pkg::otic_addr_t reg_addr,
  input wire otic_pkg::otic_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output otic_pkg::otic_word_t reg_rdata,
  input wire logic reference_capture_pin,
  output logic capture_irq,
  output logic clock_observe_pin,
  output logic clock_observe_oe,
  output otic_pkg::otic_byte_t osc_trim_value,
  output logic osc_trim_slower,
  output logic [6:0] osc_trim_step
);
  import otic_pkg::*;

  // --------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------
  function automatic logic hit(input otic_addr_t a, input otic_addr_t ofs,
                               input logic stb);
    return stb && (a == ofs);
  endfunction

  otic_byte_t mode_q;
  otic_byte_t clkctl_q;
  otic_byte_t irqen_q;
  otic_byte_t ioa_q;
  otic_byte_t ioc_q;
  otic_byte_t ckstat_q;
  otic_byte_t prot_q;
  otic_byte_t trim_q;
  otic_word_t count_q;
  otic_word_t prim_q;
  otic_word_t buf_q;
  otic_word_t rdata_q;
  otic_word_t rd_val;
  logic [2:0] pre_q;
  logic [1:0] flag_q;
  logic [1:0] armed_q;
  logic [1:0] event_d;
  logic run;
  logic buf_en;
  logic cap_mode;
  logic tick;
  logic count_adv;
  logic cmp_a;
  logic cap_a;
  logic clr_on_cmp;
  logic wrap_ev;

  otic_ref_if ref_if ();

  // Reference pin synchroniser
  otic_ref_sync u_ref_sync
  (
    .clock(clock),
    .rst(rst),
    .ref_pin(reference_capture_pin),
    .ref_o(ref_if)
  );

  // --------------------------------------------------------------------
  // Control byte registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mode_q <= CTL_RST;
      clkctl_q <= CTL_RST;
      irqen_q <= CTL_RST;
      ioa_q <= CTL_RST;
      ioc_q <= CTL_RST;
      ckstat_q <= CTL_RST;
    end
    else
    begin
      if (hit(reg_addr, OFS_MODE, reg_wr))
        mode_q <= reg_wdata[7:0];
      if (hit(reg_addr, OFS_CLKCTL, reg_wr))
        clkctl_q <= reg_wdata[7:0];
      if (hit(reg_addr, OFS_IRQEN, reg_wr))
        irqen_q <= reg_wdata[7:0];
      if (hit(reg_addr, OFS_IOA, reg_wr))
        ioa_q <= reg_wdata[7:0];
      if (hit(reg_addr, OFS_IOC, reg_wr))
        ioc_q <= reg_wdata[7:0];
      if (hit(reg_addr, OFS_CKSTAT, reg_wr))
        ckstat_q <= reg_wdata[7:0] & CKSTAT_KEEP_MASK;
    end
  end

  assign run = mode_q[MODE_RUN_BIT];
  assign buf_en = mode_q[MODE_BUF_BIT];
  assign cap_mode = ioa_q[IO_CAPTURE_BIT];
  assign clr_on_cmp = clkctl_q[CLK_CLR_BIT];

  // --------------------------------------------------------------------
  // Prescaler and count tick selection
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      pre_q <= PRESCALE_RST;
    else
      pre_q <= pre_q + 3'h1;
  end

  // Event-input codes never tick: no event pin on this block
  always_comb
  begin
    unique case (clkctl_q[CLK_SEL_HI:CLK_SEL_LO])
      OTIC_CKS_DIV1: tick = 1'b1;
      OTIC_CKS_DIV2: tick = pre_q[0];
      OTIC_CKS_DIV4: tick = &pre_q[1:0];
      OTIC_CKS_DIV8: tick = &pre_q;
      default: tick = 1'b0;
    endcase
  end

  assign count_adv = run && tick;
  assign cmp_a = !cap_mode && count_adv && (count_q == prim_q);
  assign cap_a = cap_mode && ref_if.rise;
  assign wrap_ev = count_adv && !(cmp_a && clr_on_cmp)
                   && (count_q == COUNT_MAX);

  // --------------------------------------------------------------------
  // Counter; a software write wins over counting
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      count_q <= COUNT_RST;
    else if (hit(reg_addr, OFS_COUNT, reg_wr))
      count_q <= reg_wdata;
    else if (cmp_a && clr_on_cmp)
      count_q <= COUNT_RST;
    else if (count_adv)
      count_q <= count_q + 16'h0001;
  end

  // --------------------------------------------------------------------
  // Primary and buffer registers; capture wins over a write
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      prim_q <= CAPTURE_RST;
    else if (cap_a)
      prim_q <= count_q;
    else if (hit(reg_addr, OFS_PRIMARY, reg_wr))
      prim_q <= reg_wdata;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      buf_q <= CAPTURE_RST;
    else if (cap_a && buf_en)
      buf_q <= prim_q;
    else if (hit(reg_addr, OFS_BUFFER, reg_wr))
      buf_q <= reg_wdata;
  end

  // --------------------------------------------------------------------
  // Sticky flags: read as one arms, write zero clears, set wins
  // --------------------------------------------------------------------
  assign event_d[0] = cap_a || cmp_a;
  assign event_d[1] = wrap_ev;

  for (genvar i = 0; i < 2; i++)
  begin : g_flag
    localparam int POS = (i == 0) ? FLAG_CAP_A_BIT : FLAG_WRAP_BIT;
    always_ff @(posedge clock)
    begin
      if (rst)
        armed_q[i] <= 1'b0;
      else if (hit(reg_addr, OFS_FLAGS, reg_rd) && flag_q[i])
        armed_q[i] <= 1'b1;
      else if (hit(reg_addr, OFS_FLAGS, reg_wr))
        armed_q[i] <= 1'b0;
    end
    always_ff @(posedge clock)
    begin
      if (rst)
        flag_q[i] <= 1'b0;
      else if (event_d[i])
        flag_q[i] <= 1'b1;
      else if (hit(reg_addr, OFS_FLAGS, reg_wr) && !reg_wdata[POS]
               && armed_q[i])
        flag_q[i] <= 1'b0;
    end
  end

  // Interrupt request from flag and enable
  assign capture_irq = flag_q[0] && irqen_q[IRQ_CAP_A_BIT];

  // --------------------------------------------------------------------
  // Protect and trim registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      prot_q <= CTL_RST;
    else if (hit(reg_addr, OFS_PROTECT, reg_wr) && !prot_q[PROT_LOCK_BIT]
             && !reg_wdata[PROT_WRI_BIT] && reg_wdata[PROT_PRWE_BIT])
      prot_q <= reg_wdata[7:0] & PROT_KEEP_MASK;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      trim_q <= TRIM_RST;
    else if (hit(reg_addr, OFS_TRIM, reg_wr) && prot_q[PROT_TRWE_BIT]
             && !prot_q[PROT_LOCK_BIT])
      trim_q <= reg_wdata[7:0];
  end

  // Trim drives the oscillator: sign picks direction, rest the step
  assign osc_trim_value = trim_q;
  assign osc_trim_slower = trim_q[TRIM_SIGN_BIT];
  assign osc_trim_step = trim_q[6:0];

  // --------------------------------------------------------------------
  // Clock observation pin
  // --------------------------------------------------------------------
  assign clock_observe_oe = ckstat_q[CKSTAT_SEL_HI:CKSTAT_SEL_LO]
                            == CKSTAT_CLKOUT;
  assign clock_observe_pin = clock_observe_oe && clock;

  // --------------------------------------------------------------------
  // Read path; data stand only in the cycle after the strobe
  // --------------------------------------------------------------------
  always_comb
  begin
    rd_val = 16'h0000;
    unique case (reg_addr)
      OFS_MODE: rd_val = {8'h00, mode_q};
      OFS_CLKCTL: rd_val = {8'h00, clkctl_q};
      OFS_IRQEN: rd_val = {8'h00, irqen_q};
      OFS_FLAGS: rd_val = {8'h00, flag_q[1], 6'h00, flag_q[0]};
      OFS_IOA: rd_val = {8'h00, ioa_q};
      OFS_IOC: rd_val = {8'h00, ioc_q};
      OFS_COUNT: rd_val = count_q;
      OFS_PRIMARY: rd_val = prim_q;
      OFS_BUFFER: rd_val = buf_q;
      OFS_CKSTAT: rd_val = {8'h00, ckstat_q};
      OFS_PROTECT: rd_val = {8'h00, prot_q};
      OFS_TRIM: rd_val = {8'h00, trim_q};
      OFS_DELTA: rd_val = prim_q - buf_q;
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_q <= 16'h0000;
    else if (reg_rd)
      rdata_q <= rd_val;
    else
      rdata_q <= 16'h0000;
  end

  assign reg_rdata = rdata_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_capture;
    cap_a;
  endsequence

  sequence s_plain_tick;
    count_adv && !cmp_a && !hit(reg_addr, OFS_COUNT, reg_wr);
  endsequence

  a_count_advance: assert property (
    s_plain_tick |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not advance by one");

  a_count_halted: assert property (
    !run && !hit(reg_addr, OFS_COUNT, reg_wr) ##1 !run |-> $stable(count_q))
    else $error("counter moved while halted");

  a_capture_load: assert property (
    s_capture |=> prim_q == $past(count_q))
    else $error("primary did not take the count on capture");

  a_buffer_shift: assert property (
    s_capture ##0 buf_en |=> buf_q == $past(prim_q) && flag_q[0])
    else $error("buffer did not take old primary on capture");

  a_flag_on_cap: assert property (
    s_capture |=> flag_q[0] [*1] ##0 (capture_irq == irqen_q[0]))
    else $error("capture flag or interrupt wrong after capture");

  a_irq_gated: assert property (
    !irqen_q[IRQ_CAP_A_BIT] |-> !capture_irq)
    else $error("interrupt raised while disabled");

  a_wrap_sets: assert property (
    wrap_ev && !hit(reg_addr, OFS_COUNT, reg_wr)
    |=> count_q == COUNT_RST && flag_q[1])
    else $error("wrap did not zero counter and set flag");

  a_flag_unarmed: assert property (
    flag_q[0] && !armed_q[0] && !hit(reg_addr, OFS_FLAGS, reg_rd)
    |=> flag_q[0])
    else $error("flag cleared without a prior read");

  a_trim_locked: assert property (
    hit(reg_addr, OFS_TRIM, reg_wr) && !prot_q[PROT_TRWE_BIT]
    |=> $stable(trim_q))
    else $error("trim changed while write protected");

  a_rdata_window: assert property (
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");

endmodule
`default_nettype wire

// File: inc/otic_pkg.sv
// Package: register map, field positions and reset values of the trim timer
package otic_pkg;

  // ----------------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------------
  typedef logic [3:0] otic_addr_t;
  typedef logic [15:0] otic_word_t;
  typedef logic [7:0] otic_byte_t;

  // Counter clock selection codes; 1xx selects an absent event input
  typedef enum logic [2:0] {
    OTIC_CKS_DIV1 = 3'b000,
    OTIC_CKS_DIV2 = 3'b001,
    OTIC_CKS_DIV4 = 3'b010,
    OTIC_CKS_DIV8 = 3'b011
  } otic_cks_e;

  // ----------------------------------------------------------------------
  // Register offsets (word index on the plain register port)
  // ----------------------------------------------------------------------
  localparam otic_addr_t OFS_MODE = 4'h0;
  localparam otic_addr_t OFS_CLKCTL = 4'h1;
  localparam otic_addr_t OFS_IRQEN = 4'h2;
  localparam otic_addr_t OFS_FLAGS = 4'h3;
  localparam otic_addr_t OFS_IOA = 4'h4;
  localparam otic_addr_t OFS_IOC = 4'h5;
  localparam otic_addr_t OFS_COUNT = 4'h6;
  localparam otic_addr_t OFS_PRIMARY = 4'h7;
  localparam otic_addr_t OFS_BUFFER = 4'h8;
  localparam otic_addr_t OFS_CKSTAT = 4'h9;
  localparam otic_addr_t OFS_PROTECT = 4'ha;
  localparam otic_addr_t OFS_TRIM = 4'hb;
  localparam otic_addr_t OFS_DELTA = 4'hc;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_BUF_BIT = 4;
  localparam int CLK_CLR_BIT = 7;
  localparam int CLK_SEL_HI = 6;
  localparam int CLK_SEL_LO = 4;
  localparam int IRQ_CAP_A_BIT = 0;
  localparam int FLAG_WRAP_BIT = 7;
  localparam int FLAG_CAP_A_BIT = 0;
  localparam int IO_CAPTURE_BIT = 2;
  localparam int CKSTAT_SEL_HI = 7;
  localparam int CKSTAT_SEL_LO = 6;
  localparam logic [1:0] CKSTAT_CLKOUT = 2'h2;
  localparam int PROT_WRI_BIT = 7;
  localparam int PROT_PRWE_BIT = 6;
  localparam int PROT_LOCK_BIT = 5;
  localparam int PROT_TRWE_BIT = 4;
  localparam otic_byte_t PROT_KEEP_MASK = 8'h30;
  localparam otic_byte_t CKSTAT_KEEP_MASK = 8'hc0;
  localparam int TRIM_SIGN_BIT = 7;

  // ----------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------
  localparam otic_word_t COUNT_RST = 16'h0000;
  localparam otic_word_t COUNT_MAX = 16'hffff;
  localparam otic_word_t CAPTURE_RST = 16'h0000;
  localparam otic_byte_t CTL_RST = 8'h00;
  localparam otic_byte_t TRIM_RST = 8'h00;
  localparam logic [2:0] PRESCALE_RST = 3'h0;

endpackage

// File: inc/otic_ref_if.sv
// Interface: synchronised reference input and its rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
interface otic_ref_if;
  logic level;
  logic rise;
  modport src
  (
    output level,
    output rise
  );
  modport dst
  (
    input level,
    input rise
  );
endinterface
`default_nettype wire

// File: rtl/otic_ref_sync.sv
// Reference pin synchroniser and rising-edge detector
`timescale 1ns/1ps
`default_nettype none
module otic_ref_sync
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ref_pin,
  otic_ref_if.src ref_o
);
  import otic_pkg::*;

  logic meta_q;
  logic sync_q;
  logic last_q;

  // --------------------------------------------------------------------
  // Two-stage synchroniser plus one delay stage
  // --------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= ref_pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge taken only from synchronised copies
  assign ref_o.level = sync_q;
  assign ref_o.rise = sync_q && !last_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_rise_from_pin: assert property (@(posedge clock) disable iff (rst)
    ref_o.rise |-> $past(ref_pin, 2) && !$past(ref_pin, 3))
    else $error("edge pulse without a synchronised pin rise");

endmodule
`default_nettype wire

// File: testbench/otic_ref_model.sv
// Reference pulse source standing at the capture pin
`timescale 1ns/1ps
`default_nettype none
module otic_ref_model
(
  input wire logic run,
  input wire logic [15:0] half_ns,
  output var logic ref_pin
);
  // ---------------------------------------------------------------------
  // Square wave, independent of the system clock phase
  // ---------------------------------------------------------------------
  initial ref_pin = 1'b0;

  // Toggle each half period while enabled; parked low when idle
  always
  begin
    if (run)
    begin
      #(half_ns) ref_pin = ~ref_pin;
    end
    else
    begin
      ref_pin = 1'b0;
      @(posedge run);
      #3.5; // Keeps later toggles clear of a clock edge while half_ns is a multiple of 12.5
    end
  end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the trim capture timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench;
  import otic_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  otic_addr_t reg_addr = 4'h0;
  otic_word_t reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  otic_word_t reg_rdata;
  logic ref_pin;
  logic ref_run = 1'b0;
  // Reference half period; rescaled to stand for the trimmed rate
  logic [15:0] ref_half = 16'd5000;
  logic capture_irq;
  logic clock_observe_pin;
  logic clock_observe_oe;
  otic_byte_t osc_trim_value;
  logic osc_trim_slower;
  logic [6:0] osc_trim_step;
  int n_fail = 0;
  int checked = 0;

  // ---------------------------------------------------------------------
  // Clock, design and reference source
  // ---------------------------------------------------------------------
  always #12.5 clock = ~clock;

  otic_top i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reference_capture_pin(ref_pin),
    .capture_irq(capture_irq), .clock_observe_pin(clock_observe_pin),
    .clock_observe_oe(clock_observe_oe), .osc_trim_value(osc_trim_value),
    .osc_trim_slower(osc_trim_slower), .osc_trim_step(osc_trim_step));

  otic_ref_model i_ref (.run(ref_run), .half_ns(ref_half),
    .ref_pin(ref_pin));

  // ---------------------------------------------------------------------
  // Register port cycles, entered just after a rising edge
  // ---------------------------------------------------------------------
  // Whole-word write, one idle cycle after it
  task automatic wr(input otic_addr_t a, input otic_word_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  // Read; data looked at mid-cycle after the strobe edge
  task automatic rd(input otic_addr_t a, output otic_word_t d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
    @(posedge clock);
  endtask

  // Load the count, run it for n extra cycles, then halt it
  task automatic run_count(input otic_word_t start, input int n);
    wr(OFS_COUNT, start);
    wr(OFS_MODE, 16'h0080);
    repeat (n) @(posedge clock);
    wr(OFS_MODE, 16'h0000);
  endtask

  // Poll the flags until a capture shows, bounded
  task automatic wait_cap();
    otic_word_t f;
    f = 16'h0000;
    for (int i = 0; i < 300 && f[FLAG_CAP_A_BIT] !== 1'b1; i++)
      rd(OFS_FLAGS, f);
    `CHK(f[FLAG_CAP_A_BIT], 1'b1)
  endtask

  // Read-then-write-zero clear of every flag
  task automatic clr_flags();
    otic_word_t f;
    rd(OFS_FLAGS, f);
    wr(OFS_FLAGS, 16'h0000);
  endtask

  // Oscillator stand-in: counts per reference period for a trim code,
  // sign bit lowering the rate; handed over as a half period in ns
  function automatic logic [15:0] osc_half(input otic_byte_t c);
    int n;
    n = 96 + $signed(c) / 8;
    return 16'(n * 25 / 2);
  endfunction

  // Counts per period after a trim change; last two captures are new
  task automatic meas(output otic_word_t n);
    ref_half <= osc_half(osc_trim_value);
    repeat (3)
    begin
      wait_cap();
      clr_flags();
    end
    rd(OFS_DELTA, n);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  // Reset values and an unmapped place
  task automatic t_reset();
    otic_word_t d;
    rd(OFS_COUNT, d);
    `CHK(d, 16'h0000)
    rd(OFS_MODE, d);
    `CHK(d, 16'h0000)
    wr(4'he, 16'hffff);
    rd(4'he, d);
    `CHK(d, 16'h0000)
    `CHK(osc_trim_value, 8'h00)
    `CHK(capture_irq, 1'b0)
    $display("test reset done");
  endtask

  // Counting on every edge, halting, and the wrap flag
  task automatic t_count();
    otic_word_t d;
    otic_word_t e;
    run_count(16'h1234, 10);
    rd(OFS_COUNT, d);
    `CHK(d, 16'h1240)
    repeat (5) @(posedge clock);
    rd(OFS_COUNT, e);
    `CHK(e, 16'h1240)
    run_count(16'hfffe, 0);
    rd(OFS_COUNT, d);
    `CHK(d, 16'h0000)
    wr(OFS_FLAGS, 16'h0000);
    rd(OFS_FLAGS, d);
    `CHK(d[FLAG_WRAP_BIT], 1'b1)
    wr(OFS_FLAGS, 16'h0000);
    rd(OFS_FLAGS, d);
    `CHK(d[FLAG_WRAP_BIT], 1'b0)
    $display("test count done");
  endtask

  // Divided count clocks, a halted event code, compare with clear
  task automatic t_clocks();
    otic_word_t d;
    for (int s = 0; s < 5; s++)
    begin
      wr(OFS_CLKCTL, 16'(s << 4));
      run_count(16'h0000, 14);
      rd(OFS_COUNT, d);
      `CHK(d, (s < 4) ? 16'(16 >> s) : 16'h0000)
    end
    wr(OFS_CLKCTL, 16'h0080);
    wr(OFS_PRIMARY, 16'h0005);
    run_count(16'h0000, 14);
    rd(OFS_COUNT, d);
    `CHK(d, 16'h0004)
    rd(OFS_FLAGS, d);
    `CHK(d[FLAG_CAP_A_BIT], 1'b1)
    wr(OFS_FLAGS, 16'h0000);
    wr(OFS_CLKCTL, 16'h0000);
    $display("test clocks done");
  endtask

  // Buffered capture from the reference, flag and interrupt gating
  task automatic t_capture();
    otic_word_t p1, p2, b, d, f;
    wr(OFS_COUNT, 16'h0000);
    wr(OFS_IOA, 16'h0004);
    wr(OFS_IRQEN, 16'h0001);
    wr(OFS_MODE, 16'h0090);
    wr(OFS_PROTECT, 16'h0050);
    wr(OFS_TRIM, 16'h007f);
    `CHK(osc_trim_value, 8'h7f)
    wr(OFS_TRIM, 16'h0000);
    `CHK(osc_trim_value, 8'h00)
    ref_run <= 1'b1;
    wait_cap();
    `CHK(capture_irq, 1'b1)
    clr_flags();
    `CHK(capture_irq, 1'b0)
    rd(OFS_PRIMARY, p1);
    wait_cap();
    clr_flags();
    rd(OFS_PRIMARY, p2);
    rd(OFS_BUFFER, b);
    rd(OFS_DELTA, d);
    `CHK(b, p1)
    `CHK(d, p2 - p1)
    `CHK(d >= 16'd399 && d <= 16'd401, 1'b1)
    wr(OFS_IRQEN, 16'h0000);
    wait_cap();
    `CHK(capture_irq, 1'b0)
    wr(OFS_IRQEN, 16'h0001);
    `CHK(capture_irq, 1'b1)
    rd(OFS_BUFFER, b);
    `CHK(b, p2)
    ref_run <= 1'b0;
    wr(OFS_MODE, 16'h0000);
    clr_flags();
    rd(OFS_FLAGS, f);
    `CHK(f[FLAG_CAP_A_BIT], 1'b0)
    $display("test capture done");
  endtask

  // Trim search from the top bit towards 90 counts, that is 9 MHz
  task automatic t_search();
    otic_word_t n;
    otic_byte_t code;
    logic fail_min;
    logic fail_range;
    code = 8'h00;
    fail_min = 1'b0;
    wr(OFS_MODE, 16'h0090);
    ref_run <= 1'b1;
    meas(n);
    if (n > 16'd90)
    begin
      code = 8'h80;
      wr(OFS_TRIM, {8'h00, code});
      meas(n);
      fail_min = n > 16'd90;
    end
    for (int b = 6; b >= 0; b--)
    begin
      code[b] = 1'b1;
      wr(OFS_TRIM, {8'h00, code});
      meas(n);
      if (n > 16'd90)
        code[b] = 1'b0;
    end
    wr(OFS_TRIM, {8'h00, code});
    meas(n);
    fail_range = n < 16'd86 || n > 16'd94;
    `CHK(fail_min, 1'b0)
    `CHK(fail_range, 1'b0)
    `CHK(osc_trim_value, code)
    `CHK(osc_trim_slower, 1'b1)
    ref_run <= 1'b0;
    wr(OFS_MODE, 16'h0000);
    wr(OFS_TRIM, 16'h0000);
    wr(OFS_PROTECT, 16'h0040);
    clr_flags();
    $display("test search done");
  endtask

  // Protected trim writes, sign bit and lock
  task automatic t_trim();
    otic_word_t d;
    wr(OFS_TRIM, 16'h0055);
    `CHK(osc_trim_value, 8'h00)
    wr(OFS_PROTECT, 16'h0050);
    wr(OFS_TRIM, 16'h0085);
    `CHK(osc_trim_value, 8'h85)
    `CHK(osc_trim_slower, 1'b1)
    `CHK(osc_trim_step, 7'h05)
    wr(OFS_PROTECT, 16'h0000);
    wr(OFS_TRIM, 16'h0012);
    `CHK(osc_trim_slower, 1'b0)
    wr(OFS_PROTECT, 16'h0060);
    wr(OFS_TRIM, 16'h0033);
    `CHK(osc_trim_value, 8'h12)
    rd(OFS_PROTECT, d);
    `CHK(d, 16'h0020)
    rd(OFS_TRIM, d);
    `CHK(d, 16'h0012)
    $display("test trim done");
  endtask

  // Clock observation on the port pin
  task automatic t_observe();
    wr(OFS_CKSTAT, 16'h0080);
    #2;
    `CHK(clock_observe_pin, 1'b1)
    `CHK(clock_observe_oe, 1'b1)
    @(negedge clock);
    #2;
    `CHK(clock_observe_pin, 1'b0)
    @(posedge clock);
    wr(OFS_CKSTAT, 16'h0040);
    #2;
    `CHK(clock_observe_oe, 1'b0)
    `CHK(clock_observe_pin, 1'b0)
    @(posedge clock);
    $display("test observe done");
  endtask

  // ---------------------------------------------------------------------
  // Verdict and run control
  // ---------------------------------------------------------------------
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence after a three-cycle reset
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_count();
    t_clocks();
    t_capture();
    t_search();
    t_trim();
    t_observe();
    complete_run();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial
  begin
    #(25 * 20000);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
